// ### rtl/ppl_defs.vh
// constants of the printer port pin logic
`ifndef PPL_DEFS_VH
`define PPL_DEFS_VH
// ==========================================
// register offsets
`define PPL_ADDR_DATA    4'h0
`define PPL_ADDR_STATUS  4'h1
`define PPL_ADDR_CTRL    4'h2
`define PPL_ADDR_MODE    4'h3
`define PPL_ADDR_EPPADR  4'h4
`define PPL_ADDR_EPPDAT  4'h5
// ==========================================
// control register bits
`define PPL_CTRL_HDV     0
`define PPL_CTRL_LFR     1
`define PPL_CTRL_INIT    2
`define PPL_CTRL_CHOOSE  3
`define PPL_CTRL_DIR     5
// ==========================================
// status register bits
`define PPL_ST_TMO       0
`define PPL_ST_FAULT     3
`define PPL_ST_ONLINE    4
`define PPL_ST_NOMEDIA   5
`define PPL_ST_ACK       6
`define PPL_ST_BUSY      7
// ==========================================
// mode and epp command bits
`define PPL_MODE_EPP     0
`define PPL_MODE_ABORT   1
`define PPL_EPP_WRITE    8
// ==========================================
// reset values
`define PPL_CTRL_RST     8'h04
`define PPL_MODE_RST     8'h00
// ==========================================
// timing: epp wait time-out in ns
`define PPL_TMO_NS       10000
`define PPL_CLK_NS       50
`define PPL_TMO_CYC      (`PPL_TMO_NS / `PPL_CLK_NS)
`endif

// ### rtl/ppl_od_pin.v
// one pin driver: driven low or high, or floated
module ppl_od_pin (
   // clock and reset
   input  wire clk,
   input  wire rst_n,
   // request
   input  wire drive_en,
   input  wire level,
   // pin
   output reg  pin_out,
   output reg  pin_oe
);
   always @(posedge clk) begin
      if (!rst_n) begin
         pin_out <= 1'b1;
         pin_oe  <= 1'b0;
      end else begin
         pin_out <= level;
         pin_oe  <= drive_en;
      end
   end
endmodule

// ### rtl/ppl_port.v
// parallel printer port pin logic with standard and epp modes
//
// The register addresses and the address-and-strobe port were decided locally.
`include "ppl_defs.vh"
module ppl_port #(
   parameter TMO_CYCLES = `PPL_TMO_CYC
) (
   // clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // register port
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // printer status inputs
   input  wire       ack_n_in,
   input  wire       busy_wait_in,
   input  wire       fault_n_in,
   input  wire       no_media_in,
   input  wire       printer_online_in,
   // data lines
   input  wire [7:0] port_data_lines_in,
   output reg  [7:0] port_data_lines_out,
   output reg  [7:0] port_data_lines_oe,
   // strobe pins
   output wire       host_data_valid_out,
   output wire       host_data_valid_oe,
   output wire       line_feed_request_out,
   output wire       line_feed_request_oe,
   output wire       printer_reset_out,
   output wire       printer_reset_oe,
   output wire       printer_choose_out,
   output wire       printer_choose_oe,
   // epp state
   output reg        epp_busy
);
   // ==========================================
   // epp state machine
   localparam [3:0] S_IDLE  = 4'b0001;
   localparam [3:0] S_STRB  = 4'b0010;
   localparam [3:0] S_WAIT  = 4'b0100;
   localparam [3:0] S_DONE  = 4'b1000;

   reg [7:0]  data_reg;
   reg [7:0]  ctrl_reg;
   reg [7:0]  mode_reg;
   reg [7:0]  rdat_reg;
   reg        tmo_reg;
   reg        ack_seen_reg;
   reg [3:0]  state_reg;
   reg        cyc_addr_reg;
   reg        cyc_write_reg;
   reg [15:0] tmo_cnt_reg;
   reg        ack_d_reg;

   wire epp_mode = mode_reg[`PPL_MODE_EPP];
   wire abort    = reg_wr && (reg_addr == `PPL_ADDR_MODE) && reg_wdata[`PPL_MODE_ABORT];
   wire epp_go   = epp_mode && (state_reg == S_IDLE) && reg_wr &&
                   ((reg_addr == `PPL_ADDR_EPPADR) || (reg_addr == `PPL_ADDR_EPPDAT));
   wire epp_rgo  = epp_mode && (state_reg == S_IDLE) && reg_rd &&
                   ((reg_addr == `PPL_ADDR_EPPADR) || (reg_addr == `PPL_ADDR_EPPDAT));
   wire strobing = (state_reg == S_STRB) || (state_reg == S_WAIT);
   wire tmo_hit  = (tmo_cnt_reg == TMO_CYCLES[15:0]);

   // ==========================================
   // registers and epp cycle
   always @(posedge clk) begin
      if (!rst_n) begin
         data_reg      <= 8'h00;
         ctrl_reg      <= `PPL_CTRL_RST;
         mode_reg      <= `PPL_MODE_RST;
         rdat_reg      <= 8'h00;
         tmo_reg       <= 1'b0;
         ack_seen_reg  <= 1'b0;
         state_reg     <= S_IDLE;
         cyc_addr_reg  <= 1'b0;
         cyc_write_reg <= 1'b0;
         tmo_cnt_reg   <= 16'h0000;
         ack_d_reg     <= 1'b1;
      end else begin
         ack_d_reg <= ack_n_in;
         // acknowledge falling edge is sticky until status read; set wins
         if (ack_d_reg && !ack_n_in)
            ack_seen_reg <= 1'b1;
         else if (reg_rd && reg_addr == `PPL_ADDR_STATUS)
            ack_seen_reg <= 1'b0;
         // in standard mode a new byte is refused while the printer is busy
         if (reg_wr && reg_addr == `PPL_ADDR_DATA && !(busy_wait_in && !epp_mode))
            data_reg <= reg_wdata;
         if (reg_wr && reg_addr == `PPL_ADDR_CTRL)
            ctrl_reg <= reg_wdata;
         if (reg_wr && reg_addr == `PPL_ADDR_MODE)
            mode_reg <= {7'h00, reg_wdata[`PPL_MODE_EPP]};
         if (reg_wr && reg_addr == `PPL_ADDR_STATUS && reg_wdata[`PPL_ST_TMO])
            tmo_reg <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               tmo_cnt_reg <= 16'h0000;
               if (epp_go || epp_rgo) begin
                  state_reg     <= S_STRB;
                  cyc_addr_reg  <= (reg_addr == `PPL_ADDR_EPPADR);
                  cyc_write_reg <= epp_go;
                  if (epp_go)
                     data_reg <= reg_wdata;
               end
            end
            S_STRB: begin
               state_reg <= S_WAIT;
            end
            S_WAIT: begin
               tmo_cnt_reg <= tmo_cnt_reg + 16'h0001;
               if (abort || !epp_mode) begin
                  state_reg <= S_IDLE;
               end else if (tmo_hit) begin
                  tmo_reg   <= 1'b1;
                  state_reg <= S_IDLE;
               end else if (busy_wait_in) begin
                  // wait released high: cycle may finish
                  state_reg <= S_DONE;
                  if (!cyc_write_reg)
                     rdat_reg <= port_data_lines_in;
               end
            end
            S_DONE: begin
               state_reg <= S_IDLE;
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // read data
   always @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `PPL_ADDR_DATA:   reg_rdata <= ctrl_reg[`PPL_CTRL_DIR] ? port_data_lines_in
                                                                   : data_reg;
            `PPL_ADDR_STATUS: reg_rdata <= {!busy_wait_in, ack_seen_reg, no_media_in,
                                            printer_online_in, fault_n_in, 2'b00,
                                            tmo_reg};
            `PPL_ADDR_CTRL:   reg_rdata <= ctrl_reg;
            `PPL_ADDR_MODE:   reg_rdata <= mode_reg;
            `PPL_ADDR_EPPADR: reg_rdata <= rdat_reg;
            `PPL_ADDR_EPPDAT: reg_rdata <= rdat_reg;
            default:          reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ==========================================
   // data line drive and busy flag
   always @(posedge clk) begin
      if (!rst_n) begin
         port_data_lines_out <= 8'h00;
         port_data_lines_oe  <= 8'h00;
         epp_busy            <= 1'b0;
      end else begin
         port_data_lines_out <= data_reg;
         if (epp_mode)
            port_data_lines_oe <= (strobing && cyc_write_reg) ? 8'hff : 8'h00;
         else
            port_data_lines_oe <= ctrl_reg[`PPL_CTRL_DIR] ? 8'h00 : 8'hff;
         epp_busy <= (state_reg != S_IDLE);
      end
   end

   // ==========================================
   // pin function select: standard or epp
   wire hdv_en  = epp_mode ? 1'b1 : ctrl_reg[`PPL_CTRL_HDV];
   wire hdv_lvl = epp_mode ? !(strobing && cyc_write_reg) : 1'b0;
   wire lfr_en  = epp_mode ? 1'b1 : ctrl_reg[`PPL_CTRL_LFR];
   wire lfr_lvl = epp_mode ? !(strobing && !cyc_addr_reg) : 1'b0;
   wire ini_en  = !ctrl_reg[`PPL_CTRL_INIT];
   wire sli_en  = epp_mode ? 1'b1 : ctrl_reg[`PPL_CTRL_CHOOSE];
   wire sli_lvl = epp_mode ? !(strobing && cyc_addr_reg) : 1'b0;

   ppl_od_pin u_hdv (
      .clk      (clk),
      .rst_n    (rst_n),
      .drive_en (hdv_en),
      .level    (hdv_lvl),
      .pin_out  (host_data_valid_out),
      .pin_oe   (host_data_valid_oe)
   );
   ppl_od_pin u_lfr (
      .clk      (clk),
      .rst_n    (rst_n),
      .drive_en (lfr_en),
      .level    (lfr_lvl),
      .pin_out  (line_feed_request_out),
      .pin_oe   (line_feed_request_oe)
   );
   ppl_od_pin u_ini (
      .clk      (clk),
      .rst_n    (rst_n),
      .drive_en (ini_en),
      .level    (1'b0),
      .pin_out  (printer_reset_out),
      .pin_oe   (printer_reset_oe)
   );
   ppl_od_pin u_sli (
      .clk      (clk),
      .rst_n    (rst_n),
      .drive_en (sli_en),
      .level    (sli_lvl),
      .pin_out  (printer_choose_out),
      .pin_oe   (printer_choose_oe)
   );
endmodule

// ### testbench/ppl_port_sva.sv
// assertions on the printer port pins
module ppl_port_sva #(
   parameter TMO_CYCLES = 200
) (
   // clock, reset and register port
   input wire       clk,
   input wire       rst_n,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   // printer inputs
   input wire       busy_wait_in,
   input wire       fault_n_in,
   input wire       no_media_in,
   input wire       printer_online_in,
   // pins
   input wire [7:0] port_data_lines_out,
   input wire       host_data_valid_out,
   input wire       host_data_valid_oe,
   input wire       line_feed_request_out,
   input wire       line_feed_request_oe,
   input wire       printer_reset_out,
   input wire       printer_reset_oe,
   input wire       printer_choose_out,
   input wire       printer_choose_oe,
   input wire       epp_busy
);
   // =========================================
   // mode tracking, pins lag the mode bit by one cycle
   logic m1;
   logic m2;
   int   bc;
   // cycles of the running epp access, to leave out the time-out end
   always @(posedge clk) bc <= (!rst_n || !epp_busy) ? 0 : bc + 1;
   always @(posedge clk) begin
      m1 <= !rst_n ? 1'b0 : (reg_wr && reg_addr == 4'h3) ? reg_wdata[0] : m1;
      m2 <= m1;
   end
   wire std = !m1 && !m2;
   wire dwr = std && reg_wr && reg_addr == 4'h0;
   wire low = !line_feed_request_out || !printer_choose_out;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // =========================================
   // assertions
   AST_STD_LOW: assert property (std |-> (!host_data_valid_oe || !host_data_valid_out)
      && (!line_feed_request_oe || !line_feed_request_out) && (!printer_reset_oe || !printer_reset_out)
      && (!printer_choose_oe || !printer_choose_out)) else $error("driven pin high");
   AST_CTRL_OE: assert property (std && reg_wr && reg_addr == 4'h2 |-> ##2
      {printer_choose_oe, printer_reset_oe, line_feed_request_oe, host_data_valid_oe}
      == (($past(reg_wdata, 2) & 8'h0f) ^ 8'h04)) else $error("enables wrong");
   AST_DATA_WR: assert property (dwr && !busy_wait_in |-> ##2
      port_data_lines_out == $past(reg_wdata, 2)) else $error("data not driven");
   AST_BUSY_HOLD: assert property (dwr && busy_wait_in |-> ##2
      port_data_lines_out == $past(port_data_lines_out, 2)) else $error("data changed");
   AST_STATUS: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[5] == $past(no_media_in)
      && reg_rdata[4] == $past(printer_online_in) && reg_rdata[3] == $past(fault_n_in))
      else $error("status wrong");
   AST_EPP_STRB: assert property ($rose(epp_busy) |-> ##[0:2] low) else $error("no strobe");
   AST_EPP_WAIT: assert property (m1 && epp_busy && bc < TMO_CYCLES && !busy_wait_in && !reg_wr
      && !$past(reg_wr)
      && low |=> low) else $error("wait not honoured");
   AST_EPP_IDLE: assert property (m1 && m2 && !epp_busy [*4] |-> line_feed_request_out
      && printer_choose_out && host_data_valid_out) else $error("strobe low when idle");
   cover property ($rose(epp_busy));
   cover property (dwr && busy_wait_in);
   cover property (m1 && reg_wr && reg_addr == 4'h3 && reg_wdata[1]);
endmodule

bind ppl_port ppl_port_sva #(.TMO_CYCLES(TMO_CYCLES)) u_sva (.*);

// ### testbench/ppl_printer_model.sv
// printer and epp peripheral at the far end of the cable
module ppl_printer_model (
   // clock and mode
   input  wire        clk,
   input  wire        epp,
   input  wire  [4:0] hold,
   input  wire        busy,
   // host pins
   input  wire        hdv,
   input  wire        hdv_oe,
   input  wire        lf,
   input  wire        ch,
   input  wire  [7:0] d_out,
   input  wire  [7:0] d_oe,
   // answers
   output logic       ack_n = 1'b1,
   output logic       wait_n = 1'b1,
   output wire  [7:0] d_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] cnt = 5'h00;
   logic [7:0] pat = 8'h0f;
   logic       seen = 1'b0;
   wire        strb = !lf || !ch;
   // released lines toggle, a strobed read returns a fixed byte
   assign d_in = (d_out & d_oe) | ((strb ? 8'h5a : pat) & ~d_oe);
   always @(posedge clk) begin
      pat <= ~pat;
      cnt <= (epp && strb) ? cnt + 5'h01 : 5'h00;
      wait_n <= epp ? (strb && cnt >= hold) : busy;
      seen <= !epp && hdv_oe && !hdv;
      ack_n <= !(!epp && hdv_oe && !hdv && !seen);
   end
endmodule

// ### testbench/ppl_port_test.sv
// self-checking bench of the printer port
module ppl_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, epp = 1'b0, busy = 1'b0;
   logic fault_n = 1'b1, no_media = 1'b0, online = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [4:0] hold = 5'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, d_in, d_out, d_oe, rd;
   logic ack_n, wait_n, hdv, hdv_oe, lf, lf_oe, ini, ini_oe, ch, ch_oe, ebusy;
   int fails = 0, comparisons = 0;
   // control value and the enables {valid, feed, reset, choose} it gives
   logic [11:0] rows [4] = '{12'h002, 12'h0fd, 12'h058, 12'h0a7};
   ppl_port #(.TMO_CYCLES(20)) DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ack_n_in(ack_n), .busy_wait_in(wait_n), .fault_n_in(fault_n), .no_media_in(no_media),
      .printer_online_in(online), .port_data_lines_in(d_in), .port_data_lines_out(d_out),
      .port_data_lines_oe(d_oe), .host_data_valid_out(hdv), .host_data_valid_oe(hdv_oe),
      .line_feed_request_out(lf), .line_feed_request_oe(lf_oe), .printer_reset_out(ini),
      .printer_reset_oe(ini_oe), .printer_choose_out(ch), .printer_choose_oe(ch_oe),
      .epp_busy(ebusy));
   ppl_printer_model FAR (.clk(clk), .epp(epp), .hold(hold), .busy(busy), .hdv(hdv),
      .hdv_oe(hdv_oe), .lf(lf), .ch(ch), .d_out(d_out), .d_oe(d_oe), .ack_n(ack_n),
      .wait_n(wait_n), .d_in(d_in));
   initial forever #25 clk = ~clk;
   task automatic give_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // one epp cycle: strobes checked in the first cycle the port is busy
   task automatic epp_cyc(input logic [3:0] a, input logic w, input logic [2:0] exp);
      if (w) wr(a, 8'h96);
      else rdr(a);
      tick(0);
      for (int i = 0; i < 8 && ebusy !== 1'b1; i++) tick(1);
      chk({hdv, lf, ch}, exp);
      if (w) chk(d_out, 8'h96);
      for (int i = 0; i < 40 && ebusy !== 1'b0; i++) tick(1);
      tick(3);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
      chk({hdv_oe, lf_oe, ini_oe, ch_oe}, 8'h00);
      chk(d_oe, 8'hff);
      foreach (rows[i]) begin
         wr(4'h2, rows[i][11:4]);
         tick(2);
         chk({hdv_oe, lf_oe, ini_oe, ch_oe}, rows[i][3:0]);
         chk({hdv, lf, ini, ch} & rows[i][3:0], 8'h00);
      end
      fault_n <= 1'b0;
      no_media <= 1'b1;
      tick(3);
      rdr(4'h1);
      chk(rd & 8'hbf, 8'hb0);
      rdr(4'h1);
      chk(rd[6], 1'b0);
      wr(4'h2, 8'h05);
      tick(4);
      rdr(4'h1);
      chk(rd[6], 1'b1);
      wr(4'h0, 8'h3c);
      tick(2);
      chk(d_out, 8'h3c);
      busy <= 1'b1;
      tick(3);
      wr(4'h0, 8'hc3);
      tick(2);
      chk(d_out, 8'h3c);
      busy <= 1'b0;
      epp <= 1'b1;
      wr(4'h3, 8'h01);
      tick(3);
      epp_cyc(4'h4, 1'b1, 3'b010);
      epp_cyc(4'h5, 1'b1, 3'b001);
      epp_cyc(4'h5, 1'b0, 3'b101);
      epp_cyc(4'h5, 1'b0, 3'b101);
      chk(rd, 8'h5a);
      hold <= 5'h0f;
      wr(4'h5, 8'h77);
      tick(5);
      chk({hdv, lf, ch}, 8'h01);
      wr(4'h3, 8'h03);
      tick(3);
      chk({hdv, lf, ch}, 8'h07);
      // wait held low past the time-out: cycle ends and status flags it
      hold <= 5'h1f;
      wr(4'h5, 8'h11);
      tick(3);
      for (int i = 0; i < 60 && ebusy !== 1'b0; i++) tick(1);
      rdr(4'h1);
      chk(rd[0], 1'b1);
      wr(4'h1, 8'h01);
      rdr(4'h1);
      chk(rd[0], 1'b0);
      give_verdict;
   end
   initial begin
      #200us;
      fails++;
      give_verdict;
   end
endmodule
